// ---- csp_port.sv ----
// Purpose: Serial host port reaching the converter's on-chip registers.
// Assumes: Register storage sits outside and answers regRdData combinationally from regAddr.
// Notes:   Serial clock is oversampled by clk_sys; it must be well below a quarter of clk_sys.
`timescale 1ns/1ps
`default_nettype none
module csp_port
   import csp_pkg::*;
#(
   parameter int unsigned DATA_W = CSP_MAX_W
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic reset,
   // Serial pins.
   input wire logic sclkPin,
   input wire logic csPin_n,
   input wire logic dinPin,
   output logic doutPin,
   output logic doutOe,
   output logic readyPin_n,
   // Configuration and reset pins.
   input wire logic polaritySelect,
   input wire logic resetPin_n,
   // Register file side.
   output logic [CSP_ADDR_W-1:0] regAddr,
   input wire logic [DATA_W-1:0] regRdData,
   output logic regWrStrobe,
   output logic [DATA_W-1:0] regWrData,
   output logic regDefaults,
   // Conversion side.
   input wire logic dataNew,
   input wire logic dataUpdateSoon
);

   // The shifters hold at most one 24-bit word.
   if (DATA_W != CSP_MAX_W)
   begin : gWidthCheck
      $error("csp_port: DATA_W must equal the widest register length");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisation and edge detection.
   ////////////////////////////////////////////////////////////////////////////

   logic sclkSync;
   logic csSync_n;
   logic dinSync;
   logic polSync;
   logic rstPinSync_n;
   logic sclkRise;
   logic sclkFall;
   logic csFall;

   // All pins pass two flip-flops before any logic reads them.
   csp_sync #(.WIDTH(5), .RST_VAL(5'h1b)) uSync (
      .clk_sys(clk_sys),
      .reset(reset),
      .pinIn({sclkPin, csPin_n, dinPin, polaritySelect, resetPin_n}),
      .syncOut({sclkSync, csSync_n, dinSync, polSync, rstPinSync_n})
   );

   // Edge pulses from the synchronised levels.
   csp_edge uEdge (
      .clk_sys(clk_sys),
      .reset(reset),
      .sclkSync(sclkSync),
      .csSync_n(csSync_n),
      .sclkRise(sclkRise),
      .sclkFall(sclkFall),
      .csFall(csFall)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Edge selection and bit counting.
   ////////////////////////////////////////////////////////////////////////////

   csp_state_t state_r;
   csp_state_t state_nxt;
   logic [CSP_CNT_W-1:0] bitCnt_r;
   logic [CSP_CNT_W-1:0] bitCnt_nxt;
   logic [DATA_W-1:0] inShift_r;
   logic [DATA_W-1:0] outShift_r;
   logic [CSP_ADDR_W-1:0] addr_r;
   logic loadReq_r;
   logic readyN_r;

   logic portActive;
   logic sampleEdge;
   logic launchEdge;
   logic [DATA_W-1:0] inShiftNext;
   logic [4:0] curLen;
   logic lastBit;
   logic cmdDone;
   logic [1:0] cmdDir;
   logic [CSP_ADDR_W-1:0] cmdAddr;
   logic cmdByteDone;
   logic writeDone;
   logic readDone;
   logic dataReadDone;
   logic stopSeen;
   logic readState;

   // The port works only while the reset pin is high and chip select is low.
   assign portActive = rstPinSync_n & ~csSync_n;
   assign sampleEdge = portActive & (polSync ? sclkRise : sclkFall);
   assign launchEdge = portActive & (polSync ? sclkFall : sclkRise);
   assign inShiftNext = {inShift_r[DATA_W-2:0], dinSync};

   // Length of the transfer under way.
   assign curLen = (state_r == CSP_EXPECT_CMD) ? CSP_LEN_BYTE : cspRegLen(addr_r);
   assign lastBit = sampleEdge & (bitCnt_r == (curLen - 5'h01));

   // Command byte decode from the bits collected so far.
   assign cmdDir = {inShiftNext[CSP_DIR1_POS], inShiftNext[CSP_DIR0_POS]};
   assign cmdAddr = inShiftNext[CSP_ADDR_MSB:0];
   assign cmdDone = lastBit & (state_r == CSP_EXPECT_CMD);
   assign cmdByteDone = sampleEdge & (bitCnt_r == 5'(CSP_CMD_LEN - 1));

   // Transfer completions.
   assign readState = (state_r == CSP_READ) | (state_r == CSP_CONT_READ);
   assign writeDone = lastBit & (state_r == CSP_WRITE);
   assign readDone = lastBit & readState;
   assign dataReadDone = readDone & (addr_r == CSP_ADDR_DATA);

   // In continuous read the input is still watched for a stop command.
   assign stopSeen = (state_r == CSP_CONT_READ) & cmdByteDone & (cmdDir == CSP_DIR_STOP);

   // Next bit count: cleared outside a frame and after each completed transfer.
   always_comb
   begin
      bitCnt_nxt = bitCnt_r;
      if (!portActive || lastBit || stopSeen)
      begin
         bitCnt_nxt = '0;
      end
      else if (sampleEdge)
      begin
         bitCnt_nxt = bitCnt_r + 5'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer.
   ////////////////////////////////////////////////////////////////////////////

   // Next state from command decode and transfer completion.
   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         CSP_EXPECT_CMD:
         begin
            if (cmdDone)
            begin
               unique case (cmdDir)
                  CSP_DIR_WRITE: state_nxt = CSP_WRITE;
                  CSP_DIR_READ: state_nxt = CSP_READ;
                  CSP_DIR_CONT: state_nxt = CSP_CONT_READ;
                  CSP_DIR_STOP: state_nxt = CSP_EXPECT_CMD;
               endcase
            end
         end
         CSP_WRITE:
         begin
            if (writeDone)
            begin
               state_nxt = CSP_EXPECT_CMD;
            end
         end
         CSP_READ:
         begin
            if (readDone)
            begin
               state_nxt = CSP_EXPECT_CMD;
            end
         end
         CSP_CONT_READ:
         begin
            if (stopSeen)
            begin
               state_nxt = CSP_EXPECT_CMD;
            end
         end
      endcase
   end

   // State, counter and address registers; the reset pin returns the port to command.
   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         state_r <= CSP_EXPECT_CMD;
         bitCnt_r <= '0;
         addr_r <= CSP_ADDR_COMM;
      end
      else if (!rstPinSync_n)
      begin
         state_r <= CSP_EXPECT_CMD;
         bitCnt_r <= '0;
         addr_r <= CSP_ADDR_COMM;
      end
      else
      begin
         state_r <= state_nxt;
         bitCnt_r <= bitCnt_nxt;
         if (cmdDone)
         begin
            addr_r <= cmdAddr;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Input shift register and write strobe.
   ////////////////////////////////////////////////////////////////////////////

   // Bits shift in on each sampling edge; the word moves out only when complete.
   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         inShift_r <= '0;
         regWrStrobe <= 1'b0;
         regWrData <= '0;
      end
      else
      begin
         regWrStrobe <= writeDone;
         if (sampleEdge)
         begin
            inShift_r <= inShiftNext;
         end
         if (writeDone)
         begin
            regWrData <= inShiftNext & ~({DATA_W{1'b1}} << curLen);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output shift register.
   ////////////////////////////////////////////////////////////////////////////

   // A load is requested when a read is set up, when chip select opens a frame in a read state before any bit,
   // and after each word of a continuous read; it acts one cycle later so that
   // the register file has seen the new address.
   logic loadNeed;
   logic [DATA_W-1:0] loadWord;
   assign loadNeed = (cmdDone & (cmdDir == CSP_DIR_READ || cmdDir == CSP_DIR_CONT))
                   | (csFall & rstPinSync_n & readState & (bitCnt_r == '0))
                   | (readDone & (state_r == CSP_CONT_READ));
   // Shorter registers are moved to the top so their first bit leads.
   assign loadWord = regRdData << (5'(DATA_W) - cspRegLen(addr_r));

   // Output shifter: parallel load, then one bit per launching edge once a bit has gone.
   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         loadReq_r <= 1'b0;
         outShift_r <= '0;
      end
      else
      begin
         loadReq_r <= loadNeed & ~stopSeen;
         if (loadReq_r)
         begin
            outShift_r <= loadWord;
         end
         else if (launchEdge && readState && bitCnt_r != '0)
         begin
            outShift_r <= {outShift_r[DATA_W-2:0], 1'b0};
         end
      end
   end

   // Data out pin follows the top bit of the output shifter; its enable follows chip select and the reset pin.
   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         doutPin <= 1'b0;
         doutOe <= 1'b0;
      end
      else
      begin
         doutPin <= outShift_r[DATA_W-1];
         doutOe <= ~csSync_n & rstPinSync_n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Ready output.
   ////////////////////////////////////////////////////////////////////////////

   // Ready goes high on a completed data read or before an update, and low when
   // a new word lands; a new word in the same cycle wins. Nothing blocks a
   // repeated read of the held word.
   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         readyN_r <= CSP_READY_N_RST;
      end
      else if (!rstPinSync_n)
      begin
         readyN_r <= 1'b1;
      end
      else if (dataNew)
      begin
         readyN_r <= 1'b0;
      end
      else if (dataUpdateSoon || dataReadDone)
      begin
         readyN_r <= 1'b1;
      end
   end

   // Ready pin and register side outputs.
   assign readyPin_n = readyN_r;
   assign regAddr = addr_r;
   assign regDefaults = ~rstPinSync_n;

endmodule
`default_nettype wire

// ---- csp_pkg.sv ----
// Purpose: Shared constants for the converter serial port.
// Assumes: Command byte carries the direction bits and a four-bit register address.
// Notes:   Register lengths are in serial bits.
package csp_pkg;

   // Width of the widest register and of the bit counter.
   localparam int unsigned CSP_MAX_W = 24;
   localparam int unsigned CSP_CNT_W = 5;

   // Command byte layout.
   localparam int unsigned CSP_CMD_LEN = 8;
   localparam int unsigned CSP_DIR1_POS = 5;
   localparam int unsigned CSP_DIR0_POS = 4;
   localparam int unsigned CSP_ADDR_MSB = 3;
   localparam int unsigned CSP_ADDR_W = 4;

   // Register addresses whose length or side effect matters here.
   localparam logic [3:0] CSP_ADDR_COMM = 4'h0;
   localparam logic [3:0] CSP_ADDR_DATA = 4'h1;
   localparam logic [3:0] CSP_ADDR_MODE = 4'h2;
   localparam logic [3:0] CSP_ADDR_FILTER = 4'h3;
   localparam logic [3:0] CSP_ADDR_DAC = 4'h4;

   // Register lengths in bits.
   localparam logic [4:0] CSP_LEN_BYTE = 5'h08;
   localparam logic [4:0] CSP_LEN_HALF = 5'h10;
   localparam logic [4:0] CSP_LEN_WORD = 5'h18;

   // Direction codes carried in the command byte.
   localparam logic [1:0] CSP_DIR_WRITE = 2'h0;
   localparam logic [1:0] CSP_DIR_READ = 2'h1;
   localparam logic [1:0] CSP_DIR_CONT = 2'h2;
   localparam logic [1:0] CSP_DIR_STOP = 2'h3;

   // Reset values.
   localparam logic CSP_READY_N_RST = 1'b1;

   // Serial port sequencer states.
   typedef enum logic [1:0] {CSP_EXPECT_CMD, CSP_WRITE, CSP_READ, CSP_CONT_READ} csp_state_t;

   // Length of a register in bits; address 0 reads as the 8-bit status register.
   function automatic logic [4:0] cspRegLen(input logic [3:0] addr);
      logic [4:0] len;
      len = CSP_LEN_WORD;
      if (addr == CSP_ADDR_COMM || addr == CSP_ADDR_DAC)
      begin
         len = CSP_LEN_BYTE;
      end
      else if (addr == CSP_ADDR_MODE)
      begin
         len = CSP_LEN_HALF;
      end
      return len;
   endfunction

endpackage

// ---- csp_sync.sv ----
// Purpose: Two-flop synchroniser for a group of pin inputs.
// Assumes: Inputs are quasi-static or slow against clk_sys.
// Notes:   Only the second stage may be read by logic.
`timescale 1ns/1ps
`default_nettype none
module csp_sync #(
   parameter int unsigned WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic reset,
   // Pins in and synchronised levels out.
   input wire logic [WIDTH-1:0] pinIn,
   output logic [WIDTH-1:0] syncOut
);

   logic [WIDTH-1:0] stage1_r;

   // Two flip-flops in series per bit.
   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         stage1_r <= RST_VAL;
         syncOut <= RST_VAL;
      end
      else
      begin
         stage1_r <= pinIn;
         syncOut <= stage1_r;
      end
   end

endmodule
`default_nettype wire

// ---- csp_edge.sv ----
// Purpose: Finds rising and falling edges of synchronised serial clock and the falling edge of chip select.
// Assumes: Inputs come from csp_sync.
// Notes:   Edge outputs are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module csp_edge (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic reset,
   // Synchronised levels.
   input wire logic sclkSync,
   input wire logic csSync_n,
   // Edge pulses.
   output logic sclkRise,
   output logic sclkFall,
   output logic csFall
);

   logic sclkPrev_r;
   logic csPrev_r;

   // Previous levels; they start at the synchroniser's reset levels so no false edge follows reset.
   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         sclkPrev_r <= 1'b1;
         csPrev_r <= 1'b1;
      end
      else
      begin
         sclkPrev_r <= sclkSync;
         csPrev_r <= csSync_n;
      end
   end

   // Edge decode.
   assign sclkRise = sclkSync & ~sclkPrev_r;
   assign sclkFall = ~sclkSync & sclkPrev_r;
   assign csFall = ~csSync_n & csPrev_r;

endmodule
`default_nettype wire

// ---- csp_port_asserts.sv ----
// Purpose: Checker bound to the serial port top.
// Assumes: Single clock domain, reset active high.
// Notes:   Watches port pins and the register and conversion side signals.
`timescale 1ns/1ps
`default_nettype none
module csp_port_asserts #(
   parameter int unsigned DATA_W = 24
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic reset,
   // Pins.
   input wire logic sclkPin,
   input wire logic csPin_n,
   input wire logic doutPin,
   input wire logic doutOe,
   input wire logic readyPin_n,
   input wire logic resetPin_n,
   // Register and conversion side.
   input wire logic regWrStrobe,
   input wire logic [DATA_W-1:0] regWrData,
   input wire logic regDefaults,
   input wire logic dataNew,
   input wire logic dataUpdateSoon
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   logic sclkPrev_r;
   logic csPrev_r;
   logic [3:0] quietCnt_r;
   logic [3:0] quietCnt_nxt;

   // Counts cycles since the serial clock or chip select pin last moved.
   assign quietCnt_nxt = (sclkPin != sclkPrev_r || csPin_n != csPrev_r) ? 4'h0 :
                         (quietCnt_r == 4'hf) ? quietCnt_r : quietCnt_r + 4'h1;

   // Registers the pin history.
   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         sclkPrev_r <= 1'b0;
         csPrev_r <= 1'b1;
         quietCnt_r <= 4'h0;
      end
      else
      begin
         sclkPrev_r <= sclkPin;
         csPrev_r <= csPin_n;
         quietCnt_r <= quietCnt_nxt;
      end
   end

   // Settling windows for the synchronised pins.
   sequence rstHeld;
      !resetPin_n [*4];
   endsequence
   sequence csLowSettled;
      (!csPin_n && resetPin_n) [*5];
   endsequence

   AST_READY_LOW: assert property (dataNew && resetPin_n && $past(resetPin_n, 3) |=> !readyPin_n)
      else $error("ready did not fall after new data");
   AST_READY_HIGH: assert property (dataUpdateSoon && !dataNew |=> readyPin_n)
      else $error("ready not high before update");
   AST_RST_PIN: assert property (rstHeld |-> readyPin_n && regDefaults && !doutOe && !regWrStrobe)
      else $error("reset pin not honoured");
   AST_STROBE_PULSE: assert property (regWrStrobe |=> !regWrStrobe)
      else $error("write strobe longer than one cycle");
   AST_WR_STABLE: assert property (!regWrStrobe |-> $stable(regWrData))
      else $error("write data moved without strobe");
   AST_CS_HIGH_NO_WRITE: assert property (csPin_n [*8] |-> !regWrStrobe)
      else $error("write while chip select high");
   AST_OE_ON: assert property (csLowSettled |-> doutOe)
      else $error("output not enabled while selected");
   AST_DOUT_QUIET: assert property (quietCnt_r >= 4'hc |-> $stable(doutPin))
      else $error("data out moved without clock edge");
endmodule
`default_nettype wire

bind csp_port csp_port_asserts #(.DATA_W(DATA_W)) chk_u (.clk_sys(clk_sys), .reset(reset), .sclkPin(sclkPin),
   .csPin_n(csPin_n), .doutPin(doutPin), .doutOe(doutOe), .readyPin_n(readyPin_n), .resetPin_n(resetPin_n),
   .regWrStrobe(regWrStrobe), .regWrData(regWrData), .regDefaults(regDefaults), .dataNew(dataNew),
   .dataUpdateSoon(dataUpdateSoon));

// ---- csp_host_model.sv ----
// Purpose: Host serial master driving the converter serial port.
// Assumes: Half bit time is 16 system clocks, 80 ns.
// Notes:   Framed mode toggles chip select per transfer.
`timescale 1ns/1ps
`default_nettype none
module csp_host_model (
   // Pacing clock.
   input wire logic clk_sys,
   // Pins from the device.
   input wire logic polaritySelect,
   input wire logic doutPin,
   // Pins to the device.
   output logic sclkPin,
   output logic csPin_n,
   output logic dinPin
);
   logic framed;
   logic contRd;

   // Idle pins at time zero.
   initial
   begin
      framed = 1'b1;
      contRd = 1'b0;
      sclkPin = 1'b1;
      csPin_n = 1'b1;
      dinPin = 1'b0;
   end

   task automatic halfBit();
      repeat (16) @(posedge clk_sys);
      #1;
   endtask

   // Parks the clock at its idle level, then selects framed or three-wire use.
   task automatic setMode(input logic fr);
      framed = fr;
      halfBit();
      sclkPin = polaritySelect;
      halfBit();
      csPin_n = fr;
      halfBit();
   endtask

   // Holds data in low while streaming reads; data lines stay separate.
   task automatic setCont(input logic on);
      contRd = on;
      if (on)
      begin
         dinPin = 1'b0;
      end
   endtask

   // Shifts n bits MSB first and collects what comes back.
   task automatic xfer(input int n, input logic [23:0] wv, output logic [23:0] rv);
      rv = '0;
      if (framed)
      begin
         dinPin = wv[n-1];
         csPin_n = 1'b0;
         halfBit();
      end
      for (int i = n - 1; i >= 0; i--)
      begin
         sclkPin = ~polaritySelect;
         dinPin = wv[i];
         halfBit();
         rv = {rv[22:0], doutPin};
         sclkPin = polaritySelect;
         halfBit();
      end
      if (framed)
      begin
         csPin_n = 1'b1;
         dinPin = contRd ? 1'b0 : ~dinPin;
         halfBit();
      end
   endtask
endmodule
`default_nettype wire

// ---- csp_port_tb.sv ----
// Purpose: Self-checking bench for the converter serial port.
// Assumes: Register contents are a pattern made from the address.
// Notes:   Host model paces all serial traffic.
`timescale 1ns/1ps
`default_nettype none
module csp_port_tb;
   logic clk_sys;
   logic reset;
   logic polaritySelect;
   logic resetPin_n;
   logic dataNew;
   logic dataUpdateSoon;
   wire logic sclkPin;
   wire logic csPin_n;
   wire logic dinPin;
   wire logic doutPin;
   wire logic doutOe;
   wire logic readyPin_n;
   wire logic regWrStrobe;
   wire logic regDefaults;
   wire logic [3:0] regAddr;
   wire logic [23:0] regRdData;
   wire logic [23:0] regWrData;
   logic [23:0] lastWr;
   logic [23:0] rv;
   logic [3:0] lastAddr;
   int numWr = 0;
   int num_errors = 0;
   int checks = 0;
   int cycles = 0;

   function automatic logic [23:0] rdVal(input logic [3:0] a);
      return {a, 20'h9c3a5};
   endfunction

   // Register file stand-in answers from the address.
   assign regRdData = rdVal(regAddr);

   csp_port #(.DATA_W(24)) dut_u (.clk_sys(clk_sys), .reset(reset), .sclkPin(sclkPin), .csPin_n(csPin_n),
      .dinPin(dinPin), .doutPin(doutPin), .doutOe(doutOe), .readyPin_n(readyPin_n), .polaritySelect(polaritySelect),
      .resetPin_n(resetPin_n), .regAddr(regAddr), .regRdData(regRdData), .regWrStrobe(regWrStrobe),
      .regWrData(regWrData), .regDefaults(regDefaults), .dataNew(dataNew), .dataUpdateSoon(dataUpdateSoon));

   csp_host_model host_u (.clk_sys(clk_sys), .polaritySelect(polaritySelect), .doutPin(doutPin),
      .sclkPin(sclkPin), .csPin_n(csPin_n), .dinPin(dinPin));

   // Clock generation.
   initial
   begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   // Records completed register writes and cuts a hang short.
   always @(posedge clk_sys)
   begin
      cycles++;
      if (regWrStrobe === 1'b1)
      begin
         numWr <= numWr + 1;
         lastWr <= regWrData;
         lastAddr <= regAddr;
      end
      if (cycles == 60000)
      begin
         num_errors++;
         stop_test();
      end
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task automatic chkVal(input logic [23:0] got, input logic [23:0] exp, input string msg);
      checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
      end
   endtask

   task automatic wrReg(input logic [3:0] a, input int n, input logic [23:0] d);
      host_u.xfer(8, {20'h0, a}, rv);
      host_u.xfer(n, d, rv);
      tick(8);
   endtask

   task automatic pulseNew();
      dataNew = 1'b1;
      tick(1);
      dataNew = 1'b0;
      tick(2);
   endtask

   task automatic tWrite();
      wrReg(4'h4, 8, 24'h00005a);
      chkVal(lastWr, 24'h00005a, "dac data");
      chkVal(24'(lastAddr), 24'h000004, "dac addr");
      host_u.xfer(8, 24'h000003, rv);
      host_u.xfer(16, 24'h008000, rv);
      chkVal(24'(numWr), 24'h000001, "early filter write");
      host_u.xfer(16, 24'h0010ff, rv);
      tick(8);
      chkVal(lastWr, 24'h800010, "filter data");
      wrReg(4'h4, 8, 24'h000023);
      chkVal(lastWr, 24'h000023, "write after trailing ones");
      chkVal(24'(numWr), 24'h000003, "write count");
   endtask

   task automatic tCont();
      host_u.xfer(8, 24'h000021, rv);
      host_u.setCont(1'b1);
      chkVal(24'(doutOe), 24'h000001, "oe while selected");
      repeat (2)
      begin
         host_u.xfer(24, 24'h000000, rv);
         chkVal(rv, rdVal(4'h1), "streamed word");
      end
      host_u.setCont(1'b0);
      host_u.xfer(8, 24'h000030, rv);
      wrReg(4'h4, 8, 24'h00003c);
      chkVal(lastWr, 24'h00003c, "write after stream stop");
   endtask

   task automatic tAbort();
      chkVal(24'(doutOe), 24'h000000, "oe while deselected");
      host_u.xfer(3, 24'h000007, rv);
      wrReg(4'h4, 8, 24'h000077);
      chkVal(lastWr, 24'h000077, "write after dropped frame");
   endtask

   task automatic tResetPin();
      int n0;
      n0 = numWr;
      resetPin_n = 1'b0;
      tick(8);
      pulseNew();
      chkVal(24'(readyPin_n), 24'h000001, "ready in device reset");
      chkVal(24'(regDefaults), 24'h000001, "defaults in device reset");
      wrReg(4'h4, 8, 24'h000011);
      chkVal(24'(numWr - n0), 24'h000000, "write in device reset");
      resetPin_n = 1'b1;
      tick(8);
      wrReg(4'h4, 8, 24'h000055);
      chkVal(lastWr, 24'h000055, "write after device reset");
   endtask

   task automatic tRead();
      pulseNew();
      chkVal(24'(readyPin_n), 24'h000000, "ready after new word");
      repeat (2)
      begin
         host_u.xfer(8, 24'h000011, rv);
         host_u.xfer(24, 24'h000000, rv);
         chkVal(rv, rdVal(4'h1), "single read word");
         tick(4);
         chkVal(24'(readyPin_n), 24'h000001, "ready after read");
      end
      pulseNew();
      dataUpdateSoon = 1'b1;
      tick(1);
      dataUpdateSoon = 1'b0;
      tick(2);
      chkVal(24'(readyPin_n), 24'h000001, "ready before update");
   endtask

   task automatic stop_test();
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0)
      begin
         $display("DONE - PASS");
      end
      else
      begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Main sequence.
   initial
   begin
      reset = 1'b1;
      polaritySelect = 1'b1;
      resetPin_n = 1'b1;
      dataNew = 1'b0;
      dataUpdateSoon = 1'b0;
      tick(5);
      reset = 1'b0;
      tick(4);
      host_u.setMode(1'b0);
      tWrite();
      tCont();
      host_u.setMode(1'b1);
      tAbort();
      tResetPin();
      polaritySelect = 1'b0;
      host_u.setMode(1'b1);
      tRead();
      stop_test();
   end
endmodule
`default_nettype wire
